// *** core/osc_ctrl_pkg.sv ***
// package: offsets, fields, reset values and counts of the oscillator enable control
package osc_ctrl_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	// register offsets
	localparam logic [7:0] OSC_CONFIG_OFS = 8'h1A;
	localparam logic [7:0] GUARD_OFS = 8'h1B;
	localparam logic [7:0] CLOCK_SELECT_OFS = 8'h10;
	localparam logic [7:0] OSC_CONFIG_TWO_OFS = 8'h1E;
	localparam logic [7:0] STATUS_OFS = 8'h20;
	localparam logic [7:0] IRQ_STATUS_OFS = 8'h21;
	localparam logic [7:0] IRQ_CLEAR_OFS = 8'h22;
	localparam logic [7:0] IRQ_ENABLE_OFS = 8'h23;
	localparam logic [7:0] TRIM_OFS = 8'h24;
	// osc_config_reg fields
	localparam int OSC_ENABLE_POS = 7;
	localparam int OSC_RESERVED_POS = 5;
	localparam logic [7:0] OSC_CONFIG_MASK = 8'hA0;
	localparam logic [7:0] OSC_CONFIG_RESET = 8'h00;
	// other fields
	localparam int PLL_CLOCK_SELECT_POS = 7;
	localparam int MONITOR_RESET_EN_POS = 1;
	localparam int GUARD_POS = 0;
	localparam logic [7:0] GUARD_UNLOCK = 8'h26;
	localparam int LOCKED_POS = 3;
	localparam int STABLE_POS = 0;
	localparam int CRYSTAL_OWNED_POS = 1;
	// interrupt event bits
	localparam int EV_STABLE = 0;
	localparam int EV_LOSS = 1;
	localparam int EV_LOCK = 2;
	localparam int EV_W = 3;
	// trim field
	localparam int TRIM_W = 5;
	localparam int TRIM_SIGN_POS = 4;
	localparam logic [4:0] TRIM_RESET = 5'h00;
	// oscillator startup qualification, in ns and cycles of the 4 ns clock
	localparam int CLK_PERIOD_PS = 4000;
	localparam int OSC_STARTUP_NS = 2000;
	localparam int OSC_STARTUP_CYC = (OSC_STARTUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int LOSS_CYC = 16;
	localparam int CNT_W = 12;
endpackage : osc_ctrl_pkg

// *** core/osc_enable_ctrl.sv ***
// module: external oscillator enable, pll reference select and register access
//
// Overview of operation
// - trim codes 00000 and 10000 switch the coefficient compensation off.
// - trim field is sign and magnitude; sign set means positive shift.
// - config writes accepted only with guard bit clear and pll select set.
// - an accepted config write clears pll locked and oscillator stable.
// - enable bit clear: oscillator off, reference is the internal rc clock.
// - enable bit set: oscillator and monitor on, qualified, reference from the oscillator.
// - stable flag set after qualification; the reference select follows the enable bit without waiting for it.
// - with monitor reset enabled, loss of oscillation raises a monitor reset.
// - once enable written one, crystal pins stay dedicated until system reset.
// - unlock value to guard register clears guard bit; other writes set it.
//
// notes on behaviour
// - the register port never stalls: a write lands at the edge that samples it,
//   read data stand in the following cycle only and read zero otherwise.
// - the guard bit gates every clock configuration register of this block;
//   it comes out of reset clear, so software may configure before locking.
// - a refused write leaves no trace: no flag moves, no counter restarts and
//   no event is raised, so software must read back to learn the outcome.
// - the config register keeps only the enable bit and the reserved bit;
//   all other positions are dropped on write and read back as zero.
// - an accepted config write restarts qualification even when the enable
//   bit keeps its value; this is the cost of clearing the stable flag.
// - qualification counts bus clock cycles while the oscillator toggles;
//   the figure is a fixed startup time, not a measurement of the crystal.
// - the toggle input is taken as synchronous; a real oscillator clock must
//   be reduced to a slow toggle and synchronised before it reaches here.
// - loss is a toggle input that stands still for the loss limit; a very
//   slow oscillator with a long limit is seen late, a short limit is noisy.
// - after a loss the stable flag stays low until toggling resumes and a
//   full qualification has run again; a dead oscillator never qualifies.
// - the monitor reset is sticky until system reset: the reset controller
//   outside is expected to act on it, this block only raises it.
// - the monitor reset enable is frozen while the oscillator runs, so the
//   monitor cannot be switched off under a running crystal.
// - the crystal pins stay owned once enable was written one, even if the
//   oscillator is later turned off; only system reset hands them back.
// - the pll locked flag follows the lock input level, is cleared by an
//   accepted config write and rises again one cycle later if lock holds.
// - events are sticky status bits: stable reached, loss seen, lock rose;
//   an event in the cycle of its clear wins over the clear.
// - the interrupt output is registered and so lags a new event by nothing
//   more than the edge that records it.
// - the trim decode is registered and lags the trim register by one cycle;
//   the analog compensation it steers is not modelled here.
// - software must wait the startup time before partial stop and must keep
//   the reserved bit at its reset value; neither is policed in hardware.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
module osc_enable_ctrl
	import osc_ctrl_pkg::*;
#(
	parameter int STARTUP_CYC = OSC_STARTUP_CYC,
	parameter int LOSS_LIMIT = LOSS_CYC
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [osc_ctrl_pkg::ADDR_W-1:0] addr_i,
	input wire logic [osc_ctrl_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [osc_ctrl_pkg::DATA_W-1:0] rdata_o,
	input wire logic osc_clock_toggle_i,
	input wire logic pll_locked_i,
	output logic osc_enable_o,
	output logic osc_monitor_enable_o,
	output logic ref_from_osc_o,
	output logic osc_stable_flag_o,
	output logic pll_locked_o,
	output logic crystal_pins_owned_o,
	output logic osc_monitor_reset_o,
	output logic tc_comp_enable_o,
	output logic signed [osc_ctrl_pkg::TRIM_W-1:0] tc_step_o,
	output logic irq_o
);
	import osc_ctrl_pkg::*;

	typedef struct packed {
		// software visible configuration
		logic [DATA_W-1:0] osc_cfg;
		logic guard;
		logic pll_sel;
		logic mon_rst_en;
		logic [TRIM_W-1:0] trim;
		// status kept by the hardware
		logic stable;
		logic locked;
		logic owned;
		// qualification and loss detection
		logic [CNT_W-1:0] qual_cnt;
		logic [CNT_W-1:0] loss_cnt;
		logic last_toggle;
		logic mon_rst;
		// sticky events and interrupt
		logic [EV_W-1:0] irq_stat;
		logic [EV_W-1:0] irq_en;
		logic irq;
		// registered read data, zero outside the read slot
		logic [DATA_W-1:0] rdata;
	} ctrl_state_t;

	ctrl_state_t state_reg;
	ctrl_state_t state_next;
	logic cfg_write_ok;
	logic [EV_W-1:0] ev;
	logic osc_quiet;
	logic qual_allowed;

	// ==========================================================
	// parameter checks
	// the counters are CNT_W wide; larger figures would wrap silently
	if (STARTUP_CYC < 1 || STARTUP_CYC >= (1 << CNT_W)) begin : g_bad_startup
		$error("bad startup count");
	end
	// a loss limit of one would fire on every sampled edge
	if (LOSS_LIMIT < 2 || LOSS_LIMIT >= (1 << CNT_W)) begin : g_bad_loss
		$error("bad loss count");
	end

	// ==========================================================
	// trim decode
	// the decode sits in its own module so that its outputs come from flops
	// and the field width can be changed in one place
	tc_trim_decode #(
		.WIDTH(TRIM_W)
	) u_trim (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.temp_coeff_trim_i(state_reg.trim),
		.tc_comp_enable_o(tc_comp_enable_o),
		.tc_step_o(tc_step_o)
	);

	// ==========================================================
	// next state
	always_comb begin
		state_next = state_reg;
		ev = '0;
		cfg_write_ok = wr_i && (addr_i == OSC_CONFIG_OFS) && !state_reg.guard
			&& state_reg.pll_sel;
		// counting on a dead oscillator would set the stable flag after a loss
		osc_quiet = (state_reg.loss_cnt >= CNT_W'(LOSS_LIMIT - 1));
		qual_allowed = state_reg.osc_cfg[OSC_ENABLE_POS] && !osc_quiet;

		// register writes other than the config register itself;
		// each protected register checks the guard bit on its own
		if (wr_i) begin
			case (addr_i)
				GUARD_OFS: begin
					state_next.guard = (wdata_i != GUARD_UNLOCK);
				end
				CLOCK_SELECT_OFS: begin
					if (!state_reg.guard) begin
						state_next.pll_sel = wdata_i[PLL_CLOCK_SELECT_POS];
					end
				end
				OSC_CONFIG_TWO_OFS: begin
					// monitor enable frozen while oscillator runs
					if (!state_reg.guard && state_reg.pll_sel
						&& !state_reg.osc_cfg[OSC_ENABLE_POS]) begin
						state_next.mon_rst_en = wdata_i[MONITOR_RESET_EN_POS];
					end
				end
				TRIM_OFS: begin
					if (!state_reg.guard) begin
						state_next.trim = wdata_i[TRIM_W-1:0];
					end
				end
				default: begin
				end
			endcase
		end

		// enable handling
		// the counters saturate so that neither can wrap back into a hit
		if (state_reg.osc_cfg[OSC_ENABLE_POS]) begin
			// oscillator qualified by counting core clock cycles up to the startup figure
			if (qual_allowed && state_reg.qual_cnt < CNT_W'(STARTUP_CYC)) begin
				state_next.qual_cnt = state_reg.qual_cnt + 1'b1;
			end
			if (qual_allowed && state_reg.qual_cnt == CNT_W'(STARTUP_CYC - 1)) begin
				state_next.stable = 1'b1;
				ev[EV_STABLE] = 1'b1;
			end
			state_next.last_toggle = osc_clock_toggle_i;
			if (osc_clock_toggle_i != state_reg.last_toggle) begin
				state_next.loss_cnt = '0;
			end else if (state_reg.loss_cnt < CNT_W'(LOSS_LIMIT)) begin
				state_next.loss_cnt = state_reg.loss_cnt + 1'b1;
			end
			if (state_reg.loss_cnt == CNT_W'(LOSS_LIMIT - 1)) begin
				ev[EV_LOSS] = 1'b1;
				state_next.stable = 1'b0;
				state_next.qual_cnt = '0;
				if (state_reg.mon_rst_en) begin
					state_next.mon_rst = 1'b1;
				end
			end
		end else begin
			state_next.qual_cnt = '0;
			state_next.loss_cnt = '0;
			state_next.stable = 1'b0;
		end

		// pll lock follows its input level; the rise is an event
		if (pll_locked_i && !state_reg.locked) begin
			state_next.locked = 1'b1;
			ev[EV_LOCK] = 1'b1;
		end else if (!pll_locked_i) begin
			state_next.locked = 1'b0;
		end

		// the config write comes last so that its clears win over the
		// lock and qualification updates of the same cycle
		if (cfg_write_ok) begin
			state_next.osc_cfg = wdata_i & OSC_CONFIG_MASK;
			state_next.locked = 1'b0;
			state_next.stable = 1'b0;
			state_next.qual_cnt = '0;
			state_next.loss_cnt = '0;
			if (wdata_i[OSC_ENABLE_POS]) begin
				state_next.owned = 1'b1;
			end
		end

		// sticky events: a set in the clear cycle survives
		if (wr_i && addr_i == IRQ_CLEAR_OFS) begin
			state_next.irq_stat = state_reg.irq_stat & ~wdata_i[EV_W-1:0];
		end
		if (wr_i && addr_i == IRQ_ENABLE_OFS) begin
			state_next.irq_en = wdata_i[EV_W-1:0];
		end
		state_next.irq_stat = state_next.irq_stat | ev;
		state_next.irq = |(state_next.irq_stat & state_next.irq_en);

		state_next.rdata = '0;
		if (rd_i) begin
			case (addr_i)
				OSC_CONFIG_OFS: begin
					// stored bits only; dropped positions read zero
					state_next.rdata = state_reg.osc_cfg;
				end
				GUARD_OFS: begin
					state_next.rdata[GUARD_POS] = state_reg.guard;
				end
				CLOCK_SELECT_OFS: begin
					state_next.rdata[PLL_CLOCK_SELECT_POS] = state_reg.pll_sel;
				end
				OSC_CONFIG_TWO_OFS: begin
					state_next.rdata[MONITOR_RESET_EN_POS] = state_reg.mon_rst_en;
				end
				STATUS_OFS: begin
					state_next.rdata[STABLE_POS] = state_reg.stable;
					state_next.rdata[CRYSTAL_OWNED_POS] = state_reg.owned;
					state_next.rdata[LOCKED_POS] = state_reg.locked;
				end
				IRQ_STATUS_OFS: begin
					state_next.rdata[EV_W-1:0] = state_reg.irq_stat;
				end
				IRQ_ENABLE_OFS: begin
					state_next.rdata[EV_W-1:0] = state_reg.irq_en;
				end
				TRIM_OFS: begin
					state_next.rdata[TRIM_W-1:0] = state_reg.trim;
				end
				default: begin
					// the clear register is write only and reads zero
					state_next.rdata = '0;
				end
			endcase
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			// pll select comes up set so the config register is writable
			// straight after reset
			state_reg <= '0;
			state_reg.osc_cfg <= OSC_CONFIG_RESET;
			state_reg.guard <= 1'b0;
			state_reg.pll_sel <= 1'b1;
			state_reg.trim <= TRIM_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================================
	// outputs
	assign rdata_o = state_reg.rdata;
	// enable, monitor and reference select share one flop on purpose:
	// separate copies could disagree for a cycle after a write, and the
	// pll must never see an enabled monitor on the internal reference
	assign osc_enable_o = state_reg.osc_cfg[OSC_ENABLE_POS];
	assign osc_monitor_enable_o = state_reg.osc_cfg[OSC_ENABLE_POS];
	assign ref_from_osc_o = state_reg.osc_cfg[OSC_ENABLE_POS];
	// status levels and sticky outputs
	assign osc_stable_flag_o = state_reg.stable;
	assign pll_locked_o = state_reg.locked;
	assign crystal_pins_owned_o = state_reg.owned;
	assign osc_monitor_reset_o = state_reg.mon_rst;
	assign irq_o = state_reg.irq;
endmodule : osc_enable_ctrl

// *** core/tc_trim_decode.sv ***
// module: decode of the temperature-coefficient trim field into a signed step
`timescale 1ns/10ps
module tc_trim_decode
	import osc_ctrl_pkg::*;
#(
	parameter int WIDTH = TRIM_W
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] temp_coeff_trim_i,
	output logic tc_comp_enable_o,
	output logic signed [WIDTH-1:0] tc_step_o
);
	typedef struct packed {
		logic en;
		logic signed [WIDTH-1:0] step;
	} dec_state_t;
	dec_state_t state_reg;
	dec_state_t state_next;
	logic [WIDTH-2:0] mag;

	// one sign bit and at least one magnitude bit are needed
	if (WIDTH < 2) begin : g_bad_width
		$error("trim width must be at least 2");
	end

	always_comb begin
		mag = temp_coeff_trim_i[WIDTH-2:0];
		state_next = state_reg;
		state_next.en = (mag != '0);
		if (temp_coeff_trim_i[WIDTH-1]) begin
			state_next.step = $signed({1'b0, mag});
		end else begin
			state_next.step = -$signed({1'b0, mag});
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign tc_comp_enable_o = state_reg.en;
	assign tc_step_o = state_reg.step;
endmodule : tc_trim_decode

// *** dv/osc_enable_ctrl_chk.sv ***
// checker: port-level properties of the oscillator enable control
`timescale 1ns/10ps
module osc_enable_ctrl_chk
	import osc_ctrl_pkg::*;
#(
	parameter int STARTUP_CYC = OSC_STARTUP_CYC,
	parameter int LOSS_LIMIT = LOSS_CYC
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic rd_i,
	input wire logic [osc_ctrl_pkg::DATA_W-1:0] rdata_o,
	input wire logic osc_enable_o,
	input wire logic osc_monitor_enable_o,
	input wire logic ref_from_osc_o,
	input wire logic osc_stable_flag_o,
	input wire logic pll_locked_o,
	input wire logic crystal_pins_owned_o,
	input wire logic osc_monitor_reset_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	// ==========
	// properties
	property p_mon; osc_monitor_enable_o == osc_enable_o; endproperty
	a_mon: assert property (p_mon) else $error("monitor enable differs");
	property p_ref; ref_from_osc_o == osc_enable_o; endproperty
	a_ref: assert property (p_ref) else $error("reference select wrong");
	property p_pins; osc_enable_o |-> crystal_pins_owned_o; endproperty
	a_pins: assert property (p_pins) else $error("pins not owned");
	property p_keep; crystal_pins_owned_o |=> crystal_pins_owned_o; endproperty
	a_keep: assert property (p_keep) else $error("pins released");
	property p_stab; osc_stable_flag_o |-> osc_enable_o; endproperty
	a_stab: assert property (p_stab) else $error("stable while disabled");
	property p_chg; $changed(osc_enable_o) |-> !osc_stable_flag_o && !pll_locked_o; endproperty
	a_chg: assert property (p_chg) else $error("flags kept after write");
	property p_rdz; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
	a_rdz: assert property (p_rdz) else $error("read data outside slot");
	// qualification finishes STARTUP_CYC cycles after the enable; this check needs a count of three or more
	property p_srise; $rose(osc_stable_flag_o) |-> $past(osc_enable_o, 3); endproperty
	a_srise: assert property (p_srise) else $error("stable too early");
	property p_mrise; $rose(osc_monitor_reset_o) |-> $past(osc_enable_o); endproperty
	a_mrise: assert property (p_mrise) else $error("monitor reset while off");
endmodule : osc_enable_ctrl_chk

bind osc_enable_ctrl osc_enable_ctrl_chk #(.STARTUP_CYC(STARTUP_CYC), .LOSS_LIMIT(LOSS_LIMIT))
	u_chk (.core_clk_i, .rst_i, .rd_i, .rdata_o, .osc_enable_o, .osc_monitor_enable_o,
	.ref_from_osc_o, .osc_stable_flag_o, .pll_locked_o, .crystal_pins_owned_o,
	.osc_monitor_reset_o);

// *** dv/testbench.sv ***
// testbench: directed and random register traffic for the oscillator enable control
`timescale 1ns/10ps
module testbench;
	import osc_ctrl_pkg::*;
	logic core_clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, tog = 0, plk = 0, run = 0;
	logic [7:0] addr_i = 0, wdata_i = 0, rdata_o, v;
	logic osc_enable_o, mon_en, ref_o, stable, locked, owned, mrst, tce, irq_o;
	logic signed [4:0] step;
	int err_count = 0, total_checks = 0, cyc = 0;
	// short counts keep the run brief
	osc_enable_ctrl #(.STARTUP_CYC(4), .LOSS_LIMIT(4)) u_dut (
		.core_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.osc_clock_toggle_i(tog), .pll_locked_i(plk), .osc_enable_o,
		.osc_monitor_enable_o(mon_en), .ref_from_osc_o(ref_o), .osc_stable_flag_o(stable),
		.pll_locked_o(locked), .crystal_pins_owned_o(owned), .osc_monitor_reset_o(mrst),
		.tc_comp_enable_o(tce), .tc_step_o(step), .irq_o);
	initial forever #2 core_clk_i = ~core_clk_i;
	// oscillator stands still when run drops, which is what loss detection watches
	always @(posedge core_clk_i) begin
		if (run) tog <= ~tog;
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			complete_run();
		end
	end
	// ==========
	// helpers
	function automatic logic [7:0] tc_exp(input logic [4:0] t);
		logic [4:0] m;
		m = {1'b0, t[3:0]};
		return {2'b00, t[3:0] != 4'h0, t[4] ? m : -m};
	endfunction : tc_exp
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, e);
	endtask : rd
	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : complete_run
	// ==========
	// main sequence
	initial begin
		void'($urandom(90));
		repeat (12) @(posedge core_clk_i);
		rst_i <= 1'b0;
		rd(OSC_CONFIG_OFS, 8'h00);
		rd(8'h05, 8'h00);
		for (int t = 0; t < 32; t++) begin
			wr(TRIM_OFS, 8'(t));
			repeat (2) @(posedge core_clk_i);
			#1 chk({2'b00, tce, step}, tc_exp(5'(t)));
		end
		wr(GUARD_OFS, 8'h00);
		wr(OSC_CONFIG_OFS, 8'h80);
		rd(OSC_CONFIG_OFS, 8'h00);
		rd(GUARD_OFS, 8'h01);
		wr(GUARD_OFS, GUARD_UNLOCK);
		wr(CLOCK_SELECT_OFS, 8'h00);
		wr(OSC_CONFIG_OFS, 8'h80);
		rd(OSC_CONFIG_OFS, 8'h00);
		wr(CLOCK_SELECT_OFS, 8'h80);
		wr(OSC_CONFIG_TWO_OFS, 8'h02);
		rd(OSC_CONFIG_TWO_OFS, 8'h02);
		rd(CLOCK_SELECT_OFS, 8'h80);
		wr(IRQ_ENABLE_OFS, 8'h03);
		rd(IRQ_ENABLE_OFS, 8'h03);
		run <= 1'b1;
		wr(OSC_CONFIG_OFS, 8'h80);
		#1 chk({3'h0, osc_enable_o, mon_en, ref_o, owned, stable}, 8'h1E);
		for (int i = 0; i < 20 && stable !== 1'b1; i++) @(posedge core_clk_i);
		repeat (2) @(posedge core_clk_i);
		#1 chk({6'h00, stable, irq_o}, 8'h03);
		rd(IRQ_STATUS_OFS, 8'h01);
		rd(STATUS_OFS, 8'h03);
		@(posedge core_clk_i);
		plk <= 1'b1;
		wr(OSC_CONFIG_OFS, 8'h80);
		#1 chk({6'h00, stable, locked}, 8'h00);
		for (int i = 0; i < 20 && stable !== 1'b1; i++) @(posedge core_clk_i);
		rd(IRQ_STATUS_OFS, 8'h05);
		wr(IRQ_CLEAR_OFS, 8'h07);
		repeat (2) @(posedge core_clk_i);
		#1 chk({7'h00, irq_o}, 8'h00);
		rd(IRQ_STATUS_OFS, 8'h00);
		wr(OSC_CONFIG_OFS, 8'h00);
		#1 chk({5'h00, osc_enable_o, ref_o, owned}, 8'h01);
		@(posedge core_clk_i);
		run <= 1'b0;
		wr(OSC_CONFIG_OFS, 8'h80);
		for (int i = 0; i < 20 && mrst !== 1'b1; i++) @(posedge core_clk_i);
		repeat (2) @(posedge core_clk_i);
		#1 chk({5'h00, mrst, stable, irq_o}, 8'h05);
		repeat (16) begin
			v = 8'($urandom()) & 8'hDF;
			wr(OSC_CONFIG_OFS, v);
			rd(OSC_CONFIG_OFS, v & OSC_CONFIG_MASK);
		end
		@(posedge core_clk_i);
		rst_i <= 1'b1;
		@(posedge core_clk_i);
		rst_i <= 1'b0;
		#1 chk({6'h00, owned, mrst}, 8'h00);
		complete_run();
	end
endmodule : testbench
